// ===== rtl/lip_consts.vh
// How it works
// - Frames longer than the loaded length count are flagged for discard.
// - Retransmissions after retransmission-timer expiry stop once the limit count wraps.
// - With extended block enabled, retry limit comes from upper byte of word 40.
// - Prescaler steps every 32 clocks; at its end timers tick and it reloads.
// - Prescale field is 8 bits, or the full 16-bit word 08 when extended.
// - Prescale 1 gives 64 clocks; 0 gives 8224, or 2,097,184 when extended.
// - Retransmission timer expiry before the response requests a control frame resend.
// - Idle timer expiry marks link down, or starts poll sequence in alternate mode.
// - Idle timer is held off when RTS control is enabled or in transparent mode.
// - Transmit ring is polled only on poll timer expiry, demand, or protocol receive.
// - Receive ring bit 15 suppresses the per-frame receive interrupt.
// - Ring sizes come from pointer bits 14:12 as powers of two.
// - Receive ring bit 11 enables remote-busy primitive code 5 on busy change.
// - Receive ring bit 10 accepts bad-checksum frames, only in transparent mode.
// - Receive ring bit 9 counts aborted frames in their own counter.
// - Receive ring bit 8 appends the full checksum and counts it in length.
// - Transmit pointer bits 10:08 give window as power of two less one.
// - Status request writes 7 words at the word-aligned status buffer address.
// - Error counters at words 44 to 56 are incremented by hardware and can also be written by software.
`ifndef LIP_CONSTS_VH
`define LIP_CONSTS_VH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define LIP_IDX_N1        7'h04
`define LIP_IDX_N2        7'h06
`define LIP_IDX_PRESCALE  7'h08
`define LIP_IDX_T1        7'h0A
`define LIP_IDX_T3        7'h0C
`define LIP_IDX_TP        7'h0E
`define LIP_IDX_RDP_HI    7'h10
`define LIP_IDX_RDP_LO    7'h12
`define LIP_IDX_TDP_HI    7'h14
`define LIP_IDX_TDP_LO    7'h16
`define LIP_IDX_SBA_HI    7'h18
`define LIP_IDX_SBA_LO    7'h1A
`define LIP_IDX_N2_EXT    7'h28
`define LIP_IDX_ERR_FIRST 7'h2C
`define LIP_IDX_ERR_LAST  7'h38
`define LIP_IDX_CTRL0     7'h40
`define LIP_IDX_CTRL2     7'h41
`define LIP_IDX_CTRL5     7'h42
`define LIP_IDX_STATUS    7'h43

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define LIP_BIT_TX_DEMAND     3
`define LIP_BIT_EXT_INIT      14
`define LIP_BIT_ALT_IDLE      12
`define LIP_BIT_RTS_CTRL      4
`define LIP_BIT_RX_IRQ_DIS    15
`define LIP_BIT_REMOTE_BUSY   11
`define LIP_BIT_BAD_CRC       10
`define LIP_BIT_ABORT_CNT     9
`define LIP_BIT_APPEND_CRC    8

// ----------------------------------------------------------------
// Reset values and timing counts
// ----------------------------------------------------------------
`define LIP_RST_WORD      16'h0000
`define LIP_PRESCALE_DIV  5'h1F
`define LIP_STAT_LAST     3'h6
`define LIP_PRIM_RBUSY    4'h5

`endif

// ===== rtl/lip_init_timers.v
// Our own choices: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`include "lip_consts.vh"

module lip_init_timers (
  // Clock and reset
  input  wire        clk,
  input  wire        rstn,
  // Wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [31:0] wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // Link events from the frame datapath
  input  wire        transparent_mode,
  input  wire        rx_frame_start,
  input  wire        rx_byte,
  input  wire        rx_frame_ok,
  input  wire        rx_bad_crc,
  input  wire        rx_abort,
  input  wire        rx_short,
  input  wire        rx_frmr,
  input  wire        rx_rej,
  input  wire        tx_rej_sent,
  input  wire        rx_sup_frame,
  input  wire        rx_remote_busy,
  input  wire        ctrl_frame_sent,
  input  wire        ctrl_resp_rcvd,
  input  wire        status_req,
  input  wire [15:0] stat_word_in,
  // Control results
  output reg         rx_discard,
  output reg         retx_req,
  output reg         retx_exhausted,
  output reg         link_down,
  output reg         poll_seq_start,
  output reg         tx_poll_go,
  output reg         rx_irq,
  output reg         prim_valid,
  output reg  [3:0]  primitive_code,
  // Ring options
  output wire        accept_bad_crc_en,
  output wire        append_crc_en,
  output wire [2:0]  rx_ring_len,
  output wire [2:0]  tx_ring_len,
  output wire [6:0]  tx_window,
  output wire [23:0] rx_ring_base,
  output wire [23:0] tx_ring_base,
  // Status buffer writer
  output reg         stat_wr_valid,
  output reg  [23:0] stat_wr_addr,
  output reg  [15:0] stat_wr_data,
  output reg  [2:0]  stat_word_idx
);

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  reg  [15:0] n1_q;
  reg  [15:0] n2_q;
  reg  [15:0] prescale_q;
  reg  [15:0] t1_q;
  reg  [15:0] t3_q;
  reg  [15:0] tp_q;
  reg  [15:0] rdp_hi_q;
  reg  [15:0] rdp_lo_q;
  reg  [15:0] tdp_hi_q;
  reg  [15:0] tdp_lo_q;
  reg  [15:0] sba_hi_q;
  reg  [15:0] sba_lo_q;
  reg  [15:0] n2x_q;
  reg  [15:0] ctrl2_q;
  reg  [15:0] ctrl5_q;
  reg         tx_demand_q;
  reg  [15:0] err_q [0:6];
  reg  [31:0] rd_d;

  wire [6:0]  idx     = wb_adr_i[8:2];
  wire        hit     = (wb_adr_i[31:9] == 23'h000000);
  wire        req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire        wr      = req & wb_we_i & hit;
  wire [15:0] wmask   = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire        ext_en  = ctrl2_q[`LIP_BIT_EXT_INIT];
  wire        err_hit = (idx >= `LIP_IDX_ERR_FIRST) && (idx <= `LIP_IDX_ERR_LAST) && ~idx[0];
  wire [2:0]  err_sel = idx[3:1] - 3'h6;

  // Byte-lane merge of a write into a 16-bit word
  function [15:0] merge;
    input [15:0] old;
    input [15:0] nw;
    input [15:0] m;
    begin
      merge = (old & ~m) | (nw & m);
    end
  endfunction

  // ----------------------------------------------------------------
  // Wishbone slave: one wait state, ack one cycle after the strobe
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (!rstn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= req;
      if (req) begin
        wb_dat_o <= rd_d;
      end
    end
  end

  // Read mux; unmapped and reserved words read zero
  always @* begin
    rd_d = 32'h00000000;
    if (hit) begin
      case (idx)
        `LIP_IDX_N1:       rd_d[15:0] = n1_q;
        `LIP_IDX_N2:       rd_d[15:0] = n2_q;
        `LIP_IDX_PRESCALE: rd_d[15:0] = prescale_q;
        `LIP_IDX_T1:       rd_d[15:0] = t1_q;
        `LIP_IDX_T3:       rd_d[15:0] = t3_q;
        `LIP_IDX_TP:       rd_d[15:0] = tp_q;
        `LIP_IDX_RDP_HI:   rd_d[15:0] = rdp_hi_q;
        `LIP_IDX_RDP_LO:   rd_d[15:0] = rdp_lo_q;
        `LIP_IDX_TDP_HI:   rd_d[15:0] = tdp_hi_q;
        `LIP_IDX_TDP_LO:   rd_d[15:0] = tdp_lo_q;
        `LIP_IDX_SBA_HI:   rd_d[15:0] = sba_hi_q;
        `LIP_IDX_SBA_LO:   rd_d[15:0] = sba_lo_q;
        `LIP_IDX_N2_EXT:   rd_d[15:0] = n2x_q;
        `LIP_IDX_CTRL0:    rd_d[`LIP_BIT_TX_DEMAND] = tx_demand_q;
        `LIP_IDX_CTRL2:    rd_d[15:0] = ctrl2_q;
        `LIP_IDX_CTRL5:    rd_d[15:0] = ctrl5_q;
        `LIP_IDX_STATUS:   rd_d[4:0] = {link_down, retx_exhausted, rx_discard, stat_wr_valid, tx_demand_q};
        default: begin
          if (err_hit) begin
            rd_d[15:0] = err_q[err_sel];
          end
        end
      endcase
    end
  end

  // Parameter words; reserved pointer bits are dropped on write
  always @(posedge clk) begin
    if (!rstn) begin
      n1_q       <= `LIP_RST_WORD;
      n2_q       <= `LIP_RST_WORD;
      prescale_q <= `LIP_RST_WORD;
      t1_q       <= `LIP_RST_WORD;
      t3_q       <= `LIP_RST_WORD;
      tp_q       <= `LIP_RST_WORD;
      rdp_hi_q   <= `LIP_RST_WORD;
      rdp_lo_q   <= `LIP_RST_WORD;
      tdp_hi_q   <= `LIP_RST_WORD;
      tdp_lo_q   <= `LIP_RST_WORD;
      sba_hi_q   <= `LIP_RST_WORD;
      sba_lo_q   <= `LIP_RST_WORD;
      n2x_q      <= `LIP_RST_WORD;
      ctrl2_q    <= `LIP_RST_WORD;
      ctrl5_q    <= `LIP_RST_WORD;
    end else if (wr) begin
      case (idx)
        `LIP_IDX_N1:       n1_q       <= merge(n1_q, wb_dat_i[15:0], wmask);
        `LIP_IDX_N2:       n2_q       <= merge(n2_q, wb_dat_i[15:0], wmask);
        `LIP_IDX_PRESCALE: prescale_q <= merge(prescale_q, wb_dat_i[15:0], wmask);
        `LIP_IDX_T1:       t1_q       <= merge(t1_q, wb_dat_i[15:0], wmask);
        `LIP_IDX_T3:       t3_q       <= merge(t3_q, wb_dat_i[15:0], wmask);
        `LIP_IDX_TP:       tp_q       <= merge(tp_q, wb_dat_i[15:0], wmask);
        `LIP_IDX_RDP_HI:   rdp_hi_q   <= merge(rdp_hi_q, wb_dat_i[15:0], wmask);
        `LIP_IDX_RDP_LO:   rdp_lo_q   <= merge(rdp_lo_q, wb_dat_i[15:0], wmask);
        `LIP_IDX_TDP_HI:   tdp_hi_q   <= merge(tdp_hi_q, wb_dat_i[15:0], wmask) & 16'h77FF;
        `LIP_IDX_TDP_LO:   tdp_lo_q   <= merge(tdp_lo_q, wb_dat_i[15:0], wmask);
        `LIP_IDX_SBA_HI:   sba_hi_q   <= merge(sba_hi_q, wb_dat_i[15:0], wmask) & 16'h00FF;
        `LIP_IDX_SBA_LO:   sba_lo_q   <= merge(sba_lo_q, wb_dat_i[15:0], wmask);
        `LIP_IDX_N2_EXT:   n2x_q      <= merge(n2x_q, wb_dat_i[15:0], wmask);
        `LIP_IDX_CTRL2:    ctrl2_q    <= merge(ctrl2_q, wb_dat_i[15:0], wmask);
        `LIP_IDX_CTRL5:    ctrl5_q    <= merge(ctrl5_q, wb_dat_i[15:0], wmask);
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Ring options
  // ----------------------------------------------------------------
  assign rx_ring_len       = rdp_hi_q[14:12];
  assign tx_ring_len       = tdp_hi_q[14:12];
  assign tx_window         = 7'h7F >> (3'h7 - tdp_hi_q[10:8]);
  assign accept_bad_crc_en = rdp_hi_q[`LIP_BIT_BAD_CRC] & transparent_mode;
  assign append_crc_en     = rdp_hi_q[`LIP_BIT_APPEND_CRC];
  // Bit 0 forced low so a careless base never yields an odd word fetch
  assign rx_ring_base      = {rdp_hi_q[7:0], rdp_lo_q[15:1], 1'b0};
  assign tx_ring_base      = {tdp_hi_q[7:0], tdp_lo_q[15:1], 1'b0};

  // ----------------------------------------------------------------
  // Prescaler: 32-clock step, then a reloading down count
  // ----------------------------------------------------------------
  reg  [4:0]  div_q;
  reg  [16:0] pre_q;
  reg         tick_q;
  wire        step      = (div_q == `LIP_PRESCALE_DIV);
  // Zero selects the longest period, one more than the field can hold
  wire [16:0] pre_load  = ext_en ? ((prescale_q == 16'h0000) ? 17'h10000 : {1'b0, prescale_q})
                                 : ((prescale_q[7:0] == 8'h00) ? 17'h00100 : {9'h000, prescale_q[7:0]});

  always @(posedge clk) begin
    if (!rstn) begin
      div_q  <= 5'h00;
      pre_q  <= 17'h00000;
      tick_q <= 1'b0;
    end else begin
      div_q  <= div_q + 5'h01;
      tick_q <= 1'b0;
      if (step) begin
        if (pre_q == 17'h00000) begin
          pre_q  <= pre_load;
          tick_q <= 1'b1;
        end else begin
          pre_q <= pre_q - 17'h00001;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Scaled timers: 0 retransmission, 1 link idle, 2 transmit poll
  // ----------------------------------------------------------------
  reg         t1_run_q;
  wire [2:0]  tmr_run;
  wire [2:0]  tmr_restart;
  wire [47:0] tmr_load = {tp_q, t3_q, t1_q};
  reg  [2:0]  tmr_exp;
  reg  [15:0] tmr_q [0:2];
  wire        idle_en = ~ctrl5_q[`LIP_BIT_RTS_CTRL] & ~transparent_mode;

  assign tmr_run     = {1'b1, idle_en, t1_run_q};
  assign tmr_restart = {tx_poll_go, rx_frame_ok | ~idle_en, ctrl_frame_sent | ctrl_resp_rcvd};

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_tmr
      // Count up from the two's complement load; expire past all ones
      always @(posedge clk) begin
        if (!rstn) begin
          tmr_q[g]   <= 16'h0000;
          tmr_exp[g] <= 1'b0;
        end else begin
          tmr_exp[g] <= 1'b0;
          if (tmr_restart[g]) begin
            tmr_q[g] <= tmr_load[16*g +: 16];
          end else if (tick_q && tmr_run[g]) begin
            if (tmr_q[g] == 16'hFFFF) begin
              tmr_exp[g] <= 1'b1;
              tmr_q[g]   <= tmr_load[16*g +: 16];
            end else begin
              tmr_q[g] <= tmr_q[g] + 16'h0001;
            end
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Retransmission control
  // ----------------------------------------------------------------
  reg  [7:0]  n2_cnt_q;
  reg         n2_wrap_q;
  wire [7:0]  n2_load = ext_en ? n2x_q[15:8] : n2_q[7:0];

  // Timer armed by a sent control frame, stopped by its response
  always @(posedge clk) begin
    if (!rstn) begin
      t1_run_q       <= 1'b0;
      n2_cnt_q       <= 8'h00;
      n2_wrap_q      <= 1'b0;
      retx_req       <= 1'b0;
      retx_exhausted <= 1'b0;
    end else begin
      retx_req <= 1'b0;
      if (ctrl_resp_rcvd) begin
        t1_run_q       <= 1'b0;
        n2_cnt_q       <= n2_load;
        n2_wrap_q      <= 1'b0;
        retx_exhausted <= 1'b0;
      end else if (tmr_exp[0]) begin
        if (n2_wrap_q) begin
          retx_exhausted <= 1'b1;
          t1_run_q       <= 1'b0;
        end else begin
          retx_req  <= 1'b1;
          n2_cnt_q  <= n2_cnt_q + 8'h01;
          // Load is the two's complement of one less than the limit, so the last allowed resend sees zero
          n2_wrap_q <= (n2_cnt_q == 8'h00);
        end
      end else if (ctrl_frame_sent) begin
        t1_run_q <= 1'b1;
        if (!t1_run_q) begin
          n2_cnt_q  <= n2_load;
          n2_wrap_q <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Frame length check
  // ----------------------------------------------------------------
  reg  [15:0] n1_cnt_q;
  reg         n1_wrap_q;

  always @(posedge clk) begin
    if (!rstn) begin
      n1_cnt_q   <= 16'h0000;
      n1_wrap_q  <= 1'b0;
      rx_discard <= 1'b0;
    end else if (rx_frame_start) begin
      n1_cnt_q   <= n1_q;
      n1_wrap_q  <= 1'b0;
      rx_discard <= 1'b0;
    end else if (rx_byte) begin
      n1_cnt_q <= n1_cnt_q + 16'h0001;
      // Zero is reached by the last allowed byte; only a later byte discards
      if (n1_cnt_q == 16'h0000) begin
        n1_wrap_q <= 1'b1;
      end
      if (n1_wrap_q) begin
        rx_discard <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Idle, polling and receive indications
  // ----------------------------------------------------------------
  reg         busy_seen_q;

  always @(posedge clk) begin
    if (!rstn) begin
      link_down      <= 1'b0;
      poll_seq_start <= 1'b0;
      tx_poll_go     <= 1'b0;
      tx_demand_q    <= 1'b0;
      rx_irq         <= 1'b0;
      prim_valid     <= 1'b0;
      primitive_code <= 4'h0;
      busy_seen_q    <= 1'b0;
    end else begin
      poll_seq_start <= 1'b0;
      rx_irq         <= rx_frame_ok & ~rdp_hi_q[`LIP_BIT_RX_IRQ_DIS];
      prim_valid     <= 1'b0;
      // Link idle expiry: disconnect or alternate poll sequence
      if (rx_frame_ok) begin
        link_down <= 1'b0;
      end else if (tmr_exp[1]) begin
        if (ctrl2_q[`LIP_BIT_ALT_IDLE]) begin
          poll_seq_start <= 1'b1;
        end else begin
          link_down <= 1'b1;
        end
      end
      // Poll on expiry, demand, or protocol-mode receive
      tx_poll_go <= ~tx_poll_go & (tmr_exp[2] | tx_demand_q |
                    (rx_frame_ok & ~transparent_mode));
      // Demand set by software wins over the clear from a poll
      if (wr && idx == `LIP_IDX_CTRL0 && wb_sel_i[0] && wb_dat_i[`LIP_BIT_TX_DEMAND]) begin
        tx_demand_q <= 1'b1;
      end else if (tx_poll_go) begin
        tx_demand_q <= 1'b0;
      end
      // Remote busy change on a supervisory frame
      if (rx_sup_frame) begin
        busy_seen_q <= rx_remote_busy;
        if (rdp_hi_q[`LIP_BIT_REMOTE_BUSY] && rx_remote_busy != busy_seen_q) begin
          prim_valid     <= 1'b1;
          primitive_code <= `LIP_PRIM_RBUSY;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Error counters: hardware increment wins over a software write
  // ----------------------------------------------------------------
  wire        abort_sep = rdp_hi_q[`LIP_BIT_ABORT_CNT];
  wire [6:0]  err_inc   = {rx_abort & abort_sep, rx_short, tx_rej_sent, rx_rej,
                           tmr_exp[0], rx_frmr, rx_bad_crc | (rx_abort & ~abort_sep)};

  generate
    for (g = 0; g < 7; g = g + 1) begin : g_err
      always @(posedge clk) begin
        if (!rstn) begin
          err_q[g] <= `LIP_RST_WORD;
        end else if (err_inc[g]) begin
          err_q[g] <= err_q[g] + 16'h0001;
        end else if (wr && err_hit && err_sel == g) begin
          err_q[g] <= merge(err_q[g], wb_dat_i[15:0], wmask);
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Status buffer writer: seven consecutive words
  // ----------------------------------------------------------------
  wire [23:0] status_buf_base = {sba_hi_q[7:0], sba_lo_q[15:1], 1'b0};

  always @(posedge clk) begin
    if (!rstn) begin
      stat_wr_valid <= 1'b0;
      stat_wr_addr  <= 24'h000000;
      stat_wr_data  <= 16'h0000;
      stat_word_idx <= 3'h0;
    end else begin
      if (stat_wr_valid) begin
        if (stat_word_idx == `LIP_STAT_LAST) begin
          stat_wr_valid <= 1'b0;
        end else begin
          stat_word_idx <= stat_word_idx + 3'h1;
          stat_wr_addr  <= stat_wr_addr + 24'h000002;
        end
      end else if (status_req) begin
        stat_wr_valid <= 1'b1;
        stat_word_idx <= 3'h0;
        stat_wr_addr  <= status_buf_base;
      end
      stat_wr_data <= stat_word_in;
    end
  end

endmodule

// ===== sim/lip_host_model.sv
`timescale 1ns/100ps
module lip_host_model (
  // Clock and reset
  input  wire        clk,
  input  wire        rstn,
  // Bench requests
  input  wire        req,
  input  wire        we,
  input  wire [31:0] adr,
  input  wire [15:0] wdat,
  output reg         done,
  output reg  [15:0] rdat,
  // Wishbone master
  output reg         wb_cyc,
  output reg         wb_we,
  output reg  [31:0] wb_adr,
  output reg  [31:0] wb_dat,
  input  wire [31:0] wb_dat_o,
  input  wire        wb_ack_o
);
  // ----------------------------------------
  // Host side of the shared block
  // ----------------------------------------
  // Software never sets reserved bits, bases stay even
  function [15:0] fix(input [31:0] a, input [15:0] d);
    case (a)
      32'h40:                 fix = d & 16'hFBFF;
      32'h50:                 fix = d & 16'h77FF;
      32'h60:                 fix = d & 16'h00FF;
      32'h48, 32'h58, 32'h68: fix = d & 16'hFFFE;
      default:                fix = d;
    endcase
  endfunction

  initial {wb_cyc, wb_we, wb_adr, wb_dat, done, rdat} = '0;

  // One classic cycle, then at least one idle cycle
  always @(posedge clk) begin
    if (!rstn) begin
      wb_cyc <= 1'b0;
      done   <= 1'b0;
    end else if (wb_cyc && wb_ack_o) begin
      wb_cyc <= 1'b0;
      rdat   <= wb_dat_o[15:0];
      done   <= 1'b1;
    end else begin
      done <= 1'b0;
      if (req && !wb_cyc && !done) begin
        {wb_cyc, wb_we, wb_adr} <= {1'b1, we, adr};
        wb_dat <= {16'h0000, fix(adr, wdat)};
      end
    end
  end
endmodule

// ===== sim/lip_init_timers_sva.sv
`timescale 1ns/100ps
module lip_init_timers_sva (
  // Clock and reset
  input logic        clk,
  input logic        rstn,
  // Bus
  input logic        wb_cyc_i,
  input logic        wb_stb_i,
  input logic        wb_ack_o,
  // Events and results
  input logic        rx_byte,
  input logic        rx_discard,
  input logic        rx_frame_ok,
  input logic        rx_irq,
  input logic        tx_poll_go,
  input logic        prim_valid,
  input logic [3:0]  primitive_code,
  input logic [6:0]  tx_window,
  input logic [23:0] rx_ring_base,
  input logic [23:0] tx_ring_base,
  input logic        stat_wr_valid,
  input logic [23:0] stat_wr_addr,
  input logic [2:0]  stat_word_idx
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // Status burst starts at word zero and lasts seven cycles
  sequence s_stat_start;
    $rose(stat_wr_valid) && stat_word_idx == 3'h0;
  endsequence
  sequence s_stat_burst;
    stat_wr_valid [*7] ##1 !stat_wr_valid;
  endsequence
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  ack_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  discard_cause_a: assert property ($rose(rx_discard) |-> $past(rx_byte)) else $error("discard w/o byte");
  irq_cause_a: assert property (rx_irq |-> $past(rx_frame_ok)) else $error("stray rx irq");
  win_shape_a: assert property ((tx_window & (tx_window + 7'h01)) == 7'h00) else $error("bad window");
  base_even_a: assert property (!rx_ring_base[0] && !tx_ring_base[0]) else $error("odd base");
  prim_code_a: assert property (prim_valid |-> primitive_code == 4'h5) else $error("bad code");
  poll_pulse_a: assert property (tx_poll_go |=> !tx_poll_go) else $error("poll held");
  stat_len_a: assert property (s_stat_start |-> s_stat_burst) else $error("bad burst");
  stat_step_a: assert property (stat_wr_valid && $past(stat_wr_valid) |->
    stat_wr_addr == $past(stat_wr_addr) + 24'h2 && stat_word_idx == $past(stat_word_idx) + 3'h1)
    else $error("bad step");
endmodule

bind lip_init_timers lip_init_timers_sva chk_u (.clk, .rstn, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .rx_byte,
  .rx_discard, .rx_frame_ok, .rx_irq, .tx_poll_go, .prim_valid, .primitive_code, .tx_window, .rx_ring_base,
  .tx_ring_base, .stat_wr_valid, .stat_wr_addr, .stat_word_idx);

// ===== sim/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  logic        clk, rstn, req, we, done, cyc, wwe, ack, tmode, rbusy;
  logic        rx_discard, retx_req, link_down, tx_poll_go, rx_irq, prim_valid, append_crc_en, stat_wr_valid;
  logic        retx_exhausted, poll_seq_start;
  logic [3:0]  primitive_code;
  logic [2:0]  rx_ring_len, tx_ring_len, stat_word_idx;
  logic [6:0]  tx_window;
  logic [23:0] rx_ring_base, tx_ring_base, stat_wr_addr;
  logic [31:0] adr, wadr, wdat, rdat32, seed;
  logic [15:0] wd, rd, ev, stw, r, v, u;
  int          bad_count, n_tests, n, k, L, npoll;

  lip_init_timers dut_u (.clk, .rstn, .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(wwe), .wb_adr_i(wadr),
    .wb_sel_i(4'h3), .wb_dat_i(wdat), .wb_dat_o(rdat32), .wb_ack_o(ack), .transparent_mode(tmode),
    .rx_frame_start(ev[2]), .rx_byte(ev[8]), .rx_frame_ok(ev[7]), .rx_bad_crc(ev[0]), .rx_abort(ev[6]),
    .rx_short(ev[5]), .rx_frmr(ev[1]), .rx_rej(ev[3]), .tx_rej_sent(ev[4]), .rx_sup_frame(ev[9]),
    .rx_remote_busy(rbusy), .ctrl_frame_sent(ev[10]), .ctrl_resp_rcvd(ev[11]), .status_req(ev[12]),
    .stat_word_in(stw), .rx_discard, .retx_req, .retx_exhausted, .link_down, .poll_seq_start,
    .tx_poll_go, .rx_irq, .prim_valid, .primitive_code, .accept_bad_crc_en(), .append_crc_en, .rx_ring_len,
    .tx_ring_len, .tx_window, .rx_ring_base, .tx_ring_base, .stat_wr_valid, .stat_wr_addr, .stat_wr_data(),
    .stat_word_idx);
  lip_host_model host_u (.clk, .rstn, .req, .we, .adr, .wdat(wd), .done, .rdat(rd), .wb_cyc(cyc),
    .wb_we(wwe), .wb_adr(wadr), .wb_dat(wdat), .wb_dat_o(rdat32), .wb_ack_o(ack));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [15:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[15:0];
  endfunction
  function automatic logic [15:0] twos(input logic [15:0] x);
    return ~x + 16'h0001;
  endfunction
  function automatic logic [6:0] win(input logic [2:0] t);
    return (7'h01 << t) - 7'h01;
  endfunction
  // Bus cycle through the host model; read data lands in r, only the watchdog ends a hang
  task automatic bus(input logic w, input logic [31:0] a, input logic [15:0] d);
    @(posedge clk) {req, we, adr, wd} <= {1'b1, w, a, d};
    while (done !== 1'b1) @(negedge clk);
    r = rd;
    @(posedge clk) req <= 1'b0;
  endtask
  // One-cycle event pulse, returns where outputs have settled
  task automatic pulse(input int b);
    @(posedge clk) {ev, stw} <= {16'h0001 << b, rnd()};
    @(posedge clk) ev <= 16'h0000;
    @(negedge clk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (bad_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Whole run is under two thousand cycles, so this only trips on a hang
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    tally_and_finish();
  end
  // Poll pulses counted as they happen, a pulse inside a bus call is not missed
  always @(posedge clk) begin
    if (!rstn) begin
      npoll <= 0;
    end else if (tx_poll_go === 1'b1) begin
      npoll <= npoll + 1;
    end
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    {rstn, req, we, adr, wd, ev, tmode, rbusy, stw, bad_count, n_tests} = '0;
    seed = 32'd70328;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    bus(1, 32'h20, 16'h0001); // before the first prescaler reload
    bus(0, 32'h10, 0);
    chk(r, 0);
    bus(1, 32'h200, 16'hFFFF);
    bus(0, 32'h200, 0);
    chk(r, 0);
    for (k = 0; k < 4; k++) begin
      v = rnd();
      bus(1, 32'h38, v);
      bus(0, 32'h38, 0);
      chk(r, v);
      v = rnd();
      u = rnd();
      bus(1, 32'h50, v);
      bus(1, 32'h58, u);
      chk(tx_ring_len, v[14:12]);
      chk(tx_window, win(v[10:8]));
      chk(tx_ring_base, {v[7:0], u[15:1], 1'b0});
    end
    bus(1, 32'h38, 16'h0000);
    v = (rnd() & 16'h70FF) | 16'h0B00;
    bus(1, 32'h40, v);
    chk(rx_ring_len, v[14:12]);
    chk(append_crc_en, 1);
    pulse(7);
    chk(rx_irq, 1);
    @(posedge clk) rbusy <= 1'b1;
    pulse(9);
    for (n = 0; n < 5 && prim_valid !== 1'b1; n++) @(negedge clk);
    chk(prim_valid, 1);
    for (k = 0; k < 7; k++) begin
      if (k == 2) continue;
      v = rnd();
      bus(1, 32'hB0 + 8 * k, v);
      pulse(k);
      bus(0, 32'hB0 + 8 * k, 0);
      chk(r, 16'(v + 16'h0001));
    end
    L = 2 + rnd() % 8;
    bus(1, 32'h10, twos(L - 1));
    pulse(2);
    repeat (L) pulse(8);
    chk(rx_discard, 0);
    pulse(8);
    chk(rx_discard, 1);
    bus(1, 32'h18, 16'h00FE);
    bus(1, 32'h28, twos(3));
    pulse(10);
    for (n = 0; n < 300 && retx_req !== 1'b1; n++) @(negedge clk);
    chk(n >= 126 && n <= 198, 1);
    // Limit of three: two more resends, then the next expiry gives up
    k = 1;
    for (n = 0; n < 900 && retx_exhausted !== 1'b1; n++) begin
      @(negedge clk);
      k += retx_req;
    end
    chk(k, 3);
    chk(retx_exhausted, 1);
    pulse(11);
    bus(1, 32'h30, 16'hFFFF);
    pulse(7);
    for (n = 0; n < 200 && link_down !== 1'b1; n++) @(negedge clk);
    chk(link_down, 1);
    bus(1, 32'h104, 16'h1000);
    pulse(7);
    for (n = 0; n < 200 && poll_seq_start !== 1'b1; n++) @(negedge clk);
    chk({poll_seq_start, link_down}, 2'b10);
    bus(1, 32'h104, 16'h0000);
    bus(1, 32'h108, 16'h0010);
    pulse(7);
    repeat (300) @(negedge clk);
    chk(link_down, 0);
    k = npoll;
    repeat (100) @(negedge clk);
    chk(npoll - k, 0);
    bus(1, 32'h100, 16'h0008);
    repeat (20) @(negedge clk);
    chk(npoll - k, 1);
    bus(1, 32'h40, v | 16'h8000);
    pulse(7);
    chk(rx_irq, 0);
    v = rnd();
    u = rnd() & 16'hFFFE;
    bus(1, 32'h60, v);
    bus(1, 32'h68, u);
    pulse(12);
    chk(stat_wr_valid, 1);
    chk(stat_wr_addr, {v[7:0], u});
    repeat (10) @(negedge clk);
    tally_and_finish();
  end
endmodule
